// file: design/ssp_defs.svh
// constants for the synchronous serial port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_MODE_TX 2'h0
`define SSP_MODE_RX 2'h1
`define SSP_MODE_TXRX 2'h2
`define SSP_CLKSEL_EXT 3'h7
`define SSP_BITS 4'h8
`define SSP_FIFO_DEPTH 4
`define SSP_CLK_MHZ 100
`define SSP_EXT_MIN_NS 40
`define SSP_DIV_BASE 8
`define SSP_HALF_CYC ((`SSP_EXT_MIN_NS * `SSP_CLK_MHZ + 999) / 1000)
`define SSP_BUF_RST 8'h00
`endif

// file: design/ssp_pkg.sv
// types shared by the serial port files
package ssp_pkg;
  typedef enum logic [1:0] {ssp_idle, ssp_wait, ssp_shift} ssp_state_t;
  typedef logic [7:0] ssp_byte_t;
endpackage

// file: design/ssp_fifo_if.sv
// valid/ready stream carrier between the port and its receive fifo
`timescale 1ns/1ps
`default_nettype none
interface ssp_fifo_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: design/ssp_fifo.sv
// small synchronous fifo with valid/ready on both sides, registered read data
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic flush_i,
  ssp_fifo_if.snk in_if,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  wire push = in_if.valid && in_if.ready;
  wire can_pop = (count != '0) && (!rvalid || out_ready_i);
  assign in_if.ready = (count != (AW+1)'(DEPTH));
  assign out_valid_o = rvalid;
  assign out_data_o = rdata;
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wptr] <= in_if.data;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || flush_i)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      if (push)
        wptr <= AW'(wptr + 1'b1);
      if (can_pop)
      begin
        rdata <= mem[rptr];
        rptr <= AW'(rptr + 1'b1);
      end
      if (can_pop)
        rvalid <= 1'b1;
      else if (out_ready_i)
        rvalid <= 1'b0;
      count <= (AW+1)'(count + (AW+1)'(push) - (AW+1)'(can_pop));
    end
  end
endmodule
`default_nettype wire

// file: design/ssp_core.sv
// eight-bit clocked synchronous serial port: tx, rx and full duplex with errors
//
// Summary of operation
// R1: mode 01 selects receive only
// R2: mode 10 full duplex, out fall, in rise
// R3: start sets active flag at next fall
// R4: receive samples input on rising edges
// R5: shift flag high first to eighth fall
// R6: eight bits to buffer, full flag, interrupt
// R7: internal clock starts within one period
// R8: tx write clears empty, rx read clears full
// R9: internal rx parks clock until buffer read
// R10: external clock overrun sets receive error
// R11: receive error discards incoming bits
// R12: second read returns shift register, full clears
// R13: after stop, eight clocks end reception
// R14: no interrupts while receive error stands
// R15: stop finishes byte, clears active, output high
// R16: software clears start before next shift
// R17: force stop halts and initializes everything
// R18: tx underrun sets error, interrupt next fall
// R19: transmit error holds output high
// R20: duplex empty at rise, interrupt with full
// R21: duplex park until read and write
// R22: duplex tx error interrupt after byte received
// R23: bit order select msb zero, lsb one
// R24: clock source 111 selects external clock
// R25: mode 00 selects transmit only
// R26: external clock synchronized before use
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_core #(
  parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [1:0] transfer_mode_field_i,
  input wire logic [2:0] clock_select_i,
  input wire logic bit_order_select_i,
  input wire logic start_control_bit_set_i,
  input wire logic start_control_bit_clr_i,
  input wire logic force_stop_bit_i,
  input wire logic tx_write_i,
  input wire ssp_pkg::ssp_byte_t tx_data_i,
  input wire logic rx_read_i,
  output ssp_pkg::ssp_byte_t rx_data_o,
  output logic start_control_bit_o,
  output logic transfer_active_flag_o,
  output logic shift_in_progress_flag_o,
  output logic transmit_empty_flag_o,
  output logic receive_full_flag_o,
  output logic transmit_error_flag_o,
  output logic receive_error_flag_o,
  output logic port_interrupt_request_o,
  output logic rx_stream_valid_o,
  input wire logic rx_stream_ready_i,
  output ssp_pkg::ssp_byte_t rx_stream_data_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_out_pin_o
);
  import ssp_pkg::*;

  ssp_state_t state;
  ssp_state_t next_state;
  logic [2:0] sck_sync;
  logic [2:0] sin_sync;
  logic ext_level;
  logic int_sck;
  logic [7:0] div_cnt;
  ssp_byte_t shreg;
  ssp_byte_t rxbuf;
  ssp_byte_t txbuf;
  logic tx_new;
  logic [3:0] bit_cnt;
  logic rd_second;
  logic irq_pend_next_fall;
  logic irq_pend_rx;
  logic tx_loaded;

  ssp_fifo_if #(.WIDTH(8)) rx_if ();

  function automatic ssp_byte_t shift_in(input ssp_byte_t v, input logic b,
                                         input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // decoded configuration
  wire ext_clk = (clock_select_i == `SSP_CLKSEL_EXT); // R24
  wire mode_tx = (transfer_mode_field_i == `SSP_MODE_TX); // R25
  wire mode_rx = (transfer_mode_field_i == `SSP_MODE_RX); // R1
  wire mode_dx = (transfer_mode_field_i == `SSP_MODE_TXRX); // R2
  wire sends = mode_tx || mode_dx;
  wire recvs = mode_rx || mode_dx;
  wire [7:0] div_half = 8'(`SSP_DIV_BASE << clock_select_i);

  // R26: edges are seen only once stages two and three agree
  wire ext_fall = (sck_sync[2:1] == 2'b00) && ext_level;
  wire ext_rise = (sck_sync[2:1] == 2'b11) && !ext_level;
  wire int_tick = (div_cnt == 8'h00);
  wire int_fall = !ext_clk && int_tick && int_sck && (state != ssp_idle);
  wire int_rise = !ext_clk && int_tick && !int_sck;
  wire sck_fall = ext_clk ? ext_fall : int_fall;
  wire sck_rise = ext_clk ? ext_rise : int_rise;
  wire sin_bit = sin_sync[2];

  // internal clock may only run when the byte's data dependencies are met
  wire rx_ready = !receive_full_flag_o;
  wire tx_ready = tx_new;
  wire int_go = mode_tx ? tx_ready : (mode_rx ? rx_ready : (rx_ready && tx_ready)); // R9 R21
  // a cleared start bit lets no new byte begin, so a stray far-end clock stays harmless
  wire byte_start = (state == ssp_wait) && sck_fall && start_control_bit_o
                    && (ext_clk || int_go); // R3 R7
  wire bit_fall = (state == ssp_shift) && sck_fall;
  // eighth fall ends the shift flag; the eighth rise brings in the last bit
  wire last_fall = bit_fall && (bit_cnt == 4'(`SSP_BITS - 4'h1)); // R5
  wire byte_done = (state == ssp_shift) && sck_rise && (bit_cnt == `SSP_BITS); // R6
  wire overrun = ext_clk && recvs && receive_full_flag_o; // R10
  wire underrun = ext_clk && sends && !tx_new; // R18 R22
  wire rx_capture = byte_done && recvs && !receive_error_flag_o; // R11
  // an overrun byte never reaches the stream copy
  wire rx_good = rx_capture && !(overrun && !rx_read_i); // R10
  // one shift per bit, at the rise: full duplex shares the register both ways
  wire shift_rise = sck_rise && (state == ssp_shift) && !(recvs && receive_error_flag_o); // R11
  wire [7:0] shreg_in = shift_in(shreg, recvs ? sin_bit : 1'b1, bit_order_select_i); // R4

  always_comb
  begin
    next_state = state;
    unique case (state)
      ssp_idle: if (start_control_bit_o) next_state = ssp_wait;
      ssp_wait: if (byte_start) next_state = ssp_shift;
                else if (!start_control_bit_o && !transfer_active_flag_o) next_state = ssp_idle;
      ssp_shift: if (byte_done) next_state = ssp_wait;
    endcase
  end

  // synchronisers, three stages each
  always_ff @(posedge clk_sys_i)
  begin
    sck_sync <= {sck_sync[1:0], serial_clock_pin_i};
    sin_sync <= {sin_sync[1:0], serial_data_in_pin_i};
    if (srst_i)
      ext_level <= 1'b1;
    else if (ext_fall || ext_rise)
      ext_level <= sck_sync[2];
  end

  // internal divider; clock parks high when idle or waiting
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || force_stop_bit_i || ext_clk)
    begin
      div_cnt <= 8'h00;
      int_sck <= 1'b1;
    end
    else if (int_tick)
    begin
      div_cnt <= 8'(div_half - 8'h01);
      if (int_sck && (state == ssp_shift) && (bit_cnt != `SSP_BITS)) int_sck <= 1'b0;
      else if (int_sck && byte_start) int_sck <= 1'b0;
      else int_sck <= 1'b1;
    end
    else
      div_cnt <= 8'(div_cnt - 8'h01);
  end
  assign serial_clock_pin_o = int_sck;
  assign serial_clock_pin_oe_o = !ext_clk;

  // control/status
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || force_stop_bit_i) // R17
    begin
      state <= ssp_idle;
      start_control_bit_o <= 1'b0;
      transfer_active_flag_o <= 1'b0;
      shift_in_progress_flag_o <= 1'b0;
      transmit_empty_flag_o <= 1'b0;
      receive_full_flag_o <= 1'b0;
      transmit_error_flag_o <= 1'b0;
      receive_error_flag_o <= 1'b0;
      port_interrupt_request_o <= 1'b0;
      irq_pend_next_fall <= 1'b0;
      irq_pend_rx <= 1'b0;
      bit_cnt <= 4'h0;
      tx_new <= 1'b0;
      tx_loaded <= 1'b0;
      rd_second <= 1'b0;
      txbuf <= `SSP_BUF_RST;
      rxbuf <= `SSP_BUF_RST;
      shreg <= `SSP_BUF_RST;
    end
    else
    begin
      state <= next_state;
      port_interrupt_request_o <= 1'b0;
      if (start_control_bit_set_i)
        start_control_bit_o <= 1'b1;
      else if (start_control_bit_clr_i)
        start_control_bit_o <= 1'b0;
      if (byte_start)
        transfer_active_flag_o <= 1'b1; // R3
      else if (state == ssp_wait && !start_control_bit_o && !byte_start)
        transfer_active_flag_o <= 1'b0; // R13 R15
      if (byte_start)
        shift_in_progress_flag_o <= 1'b1; // R5
      else if (last_fall)
        shift_in_progress_flag_o <= 1'b0; // R5
      // bit counter counts falling edges of the byte
      if (byte_start)
        bit_cnt <= 4'h1;
      else if (bit_fall)
        bit_cnt <= 4'(bit_cnt + 4'h1);
      // transmit side
      if (tx_write_i)
      begin
        txbuf <= tx_data_i;
        tx_new <= 1'b1;
        transmit_empty_flag_o <= 1'b0; // R8
      end
      if (byte_start && sends)
      begin
        if (tx_new && !tx_write_i)
        begin
          shreg <= txbuf;
          tx_new <= 1'b0;
          tx_loaded <= 1'b1;
        end
        else if (underrun && !tx_write_i)
        begin
          transmit_error_flag_o <= 1'b1; // R18 R22
          if (mode_tx)
            irq_pend_next_fall <= 1'b1; // R18
        end
      end
      else if (shift_rise)
        shreg <= shreg_in; // R4 R23
      if (sck_rise && tx_loaded)
      begin
        tx_loaded <= 1'b0;
        transmit_empty_flag_o <= 1'b1; // R20
        if (mode_tx)
          irq_pend_next_fall <= 1'b1;
      end
      if (irq_pend_next_fall && sck_fall)
      begin
        irq_pend_next_fall <= 1'b0;
        port_interrupt_request_o <= !receive_error_flag_o; // R14
      end
      // receive side
      if (rx_read_i && receive_full_flag_o)
      begin
        if (receive_error_flag_o && !rd_second)
        begin
          rd_second <= 1'b1; // R12
          rxbuf <= shreg;
        end
        else
        begin
          receive_full_flag_o <= 1'b0; // R8
          receive_error_flag_o <= 1'b0; // R12
          rd_second <= 1'b0;
        end
      end
      if (byte_done && recvs)
      begin
        if (overrun && !rx_read_i)
        begin
          if (!receive_error_flag_o)
            port_interrupt_request_o <= 1'b1; // R10 R14
          receive_error_flag_o <= 1'b1; // R10
        end
        else if (rx_capture)
        begin
          rxbuf <= shreg_in; // R6
          receive_full_flag_o <= 1'b1; // R6
          port_interrupt_request_o <= 1'b1; // R6 R20 R22
        end
      end
    end
  end

  // serial output: idle high, high on transmit error
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || force_stop_bit_i)
      serial_data_out_pin_o <= 1'b1;
    else if (!sends || transmit_error_flag_o || state != ssp_shift && !byte_start)
      serial_data_out_pin_o <= 1'b1; // R15 R19
    else if (byte_start && tx_new)
      serial_data_out_pin_o <= bit_order_select_i ? txbuf[0] : txbuf[7]; // R23
    else if (bit_fall && bit_cnt != `SSP_BITS)
      serial_data_out_pin_o <= bit_order_select_i ? shreg[0] : shreg[7];
  end

  assign rx_data_o = rxbuf;
  assign rx_if.valid = rx_good;
  assign rx_if.data = shreg_in;

  ssp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .flush_i(force_stop_bit_i),
    .in_if(rx_if),
    .out_valid_o(rx_stream_valid_o),
    .out_ready_i(rx_stream_ready_i),
    .out_data_o(rx_stream_data_o)
  );
endmodule
`default_nettype wire

// file: verif/ssp_chk.sv
// concurrent checks on the serial port flags and pins
`timescale 1ns/1ps
`default_nettype none
module ssp_chk (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic force_stop_bit_i,
  input wire logic start_control_bit_o,
  input wire logic transfer_active_flag_o,
  input wire logic shift_in_progress_flag_o,
  input wire logic receive_full_flag_o,
  input wire logic transmit_error_flag_o,
  input wire logic receive_error_flag_o,
  input wire logic port_interrupt_request_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_data_out_pin_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  chk_force_init: assert property (force_stop_bit_i |=> !start_control_bit_o
    && !transfer_active_flag_o && !receive_full_flag_o && !receive_error_flag_o
    && !transmit_error_flag_o) else $error("force stop left state behind");
  chk_transmit_error_flag_high: assert property (transmit_error_flag_o && $past(transmit_error_flag_o)
    |-> serial_data_out_pin_o) else $error("data out low during transmit error");
  chk_receive_error_flag_quiet: assert property (receive_error_flag_o && $past(receive_error_flag_o, 2)
    |-> !port_interrupt_request_o) else $error("interrupt while receive error stands");
  chk_full_irq: assert property ($rose(receive_full_flag_o)
    |-> ##[0:1] port_interrupt_request_o) else $error("full without interrupt");
  chk_park_clock: assert property ($fell(serial_clock_pin_o) && serial_clock_pin_oe_o
    |-> !$past(receive_full_flag_o)) else $error("clock ran while buffer full");
  chk_active_shift: assert property ($rose(transfer_active_flag_o)
    |-> shift_in_progress_flag_o) else $error("active rose without shift");
  chk_shift_inside: assert property (shift_in_progress_flag_o
    |-> transfer_active_flag_o) else $error("shift flag outside transfer");
  chk_stop_done: assert property ($fell(transfer_active_flag_o)
    |-> !start_control_bit_o && !shift_in_progress_flag_o) else $error("stopped mid byte");
  cover property (port_interrupt_request_o);
  cover property ($rose(receive_error_flag_o));
  cover property ($rose(transmit_error_flag_o));
endmodule
bind ssp_core ssp_chk i_chk (
  .clk_sys_i, .srst_i, .force_stop_bit_i, .start_control_bit_o, .transfer_active_flag_o,
  .shift_in_progress_flag_o, .receive_full_flag_o, .transmit_error_flag_o,
  .receive_error_flag_o, .port_interrupt_request_o, .serial_clock_pin_o,
  .serial_clock_pin_oe_o, .serial_data_out_pin_o
);
`default_nettype wire

// file: verif/ssp_partner.sv
// far-end serial device: clock source when external, data source and sink always
`timescale 1ns/1ps
`default_nettype none
module ssp_partner (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic ext_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic sdi_o,
  output logic [7:0] rx_o,
  output logic busy_o
);
  // 60 ns half period, above the 40 ns minimum pulse width
  localparam int HALF = 6;
  int tmr = 0;
  int tog = 0;
  int cnt = 0;
  logic sck_q = 1'b1;
  initial
  begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    rx_o = 8'h00;
    busy_o = 1'b0;
  end
  always @(posedge clk_sys_i)
  begin
    sck_q <= sck_i;
    if (go_i)
    begin
      cnt <= 0;
      tmr <= 0;
      tog <= 0;
      busy_o <= ext_i;
    end
    else if (busy_o)
    begin
      tmr <= (tmr == HALF - 1) ? 0 : tmr + 1;
      if (tmr == HALF - 1)
      begin
        sck_o <= ~sck_o;
        tog <= tog + 1;
        if (tog == 15)
          busy_o <= 1'b0;
      end
    end
    if (sck_q && !sck_i)
    begin
      sdi_o <= tx_i[lsb_i ? cnt % 8 : 7 - cnt % 8];
      cnt <= cnt % 8 + 1;
    end
    else if (!sck_q && sck_i)
      rx_o <= lsb_i ? {sdo_i, rx_o[7:1]} : {rx_o[6:0], sdo_i};
    // outside a frame the line carries no data, so it keeps moving
    else if (sck_i && (cnt == 0 || cnt == 8))
      sdi_o <= ~sdi_o;
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module tb_top;
  import ssp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [2:0] sel = 3'h0;
  logic lsb = 1'b0, set = 1'b0, clr = 1'b0, stop = 1'b0, wr = 1'b0, rd = 1'b0, rdy = 1'b0;
  logic go = 1'b0, ext = 1'b0;
  ssp_byte_t txd = 8'h00, pb = 8'h00, rxd, sd, prx;
  logic st, act, sh, emp, full, txe, rxe, irq, sv, sck_o, sck_oe, sdo, pck, sdi, pbusy;
  wire logic sck = sck_oe ? sck_o : pck;
  int failures = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h0000_801d;
  ssp_byte_t q[$];
  ssp_core i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .transfer_mode_field_i(mode),
    .clock_select_i(sel), .bit_order_select_i(lsb), .start_control_bit_set_i(set),
    .start_control_bit_clr_i(clr), .force_stop_bit_i(stop), .tx_write_i(wr), .tx_data_i(txd),
    .rx_read_i(rd), .rx_data_o(rxd), .start_control_bit_o(st), .transfer_active_flag_o(act),
    .shift_in_progress_flag_o(sh), .transmit_empty_flag_o(emp), .receive_full_flag_o(full),
    .transmit_error_flag_o(txe), .receive_error_flag_o(rxe), .port_interrupt_request_o(irq),
    .rx_stream_valid_o(sv), .rx_stream_ready_i(rdy), .rx_stream_data_o(sd),
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
    .serial_data_in_pin_i(sdi), .serial_data_out_pin_o(sdo));
  ssp_partner i_far (.clk_sys_i(clk_sys_i), .go_i(go), .ext_i(ext), .lsb_i(lsb), .tx_i(pb),
    .sck_i(sck), .sdo_i(sdo), .sck_o(pck), .sdi_o(sdi), .rx_o(prx), .busy_o(pbusy));
  always #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input ssp_byte_t e, input ssp_byte_t g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ctl(input logic s, input logic c, input logic f, input logic w, input logic r);
    @(posedge clk_sys_i);
    {set, clr, stop, wr, rd} <= {s, c, f, w, r};
    @(posedge clk_sys_i);
    {set, clr, stop, wr, rd} <= 5'h00;
  endtask
  task automatic cfg(input logic [1:0] m, input logic [2:0] s, input logic l);
    @(posedge clk_sys_i);
    mode <= m;
    sel <= s;
    lsb <= l;
    ext <= (s == `SSP_CLKSEL_EXT);
  endtask
  // external mode: one full byte of clocks; internal mode: only loads the far-end byte and realigns the bit count
  task automatic frame(input ssp_byte_t b);
    @(posedge clk_sys_i);
    pb <= b;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do @(negedge clk_sys_i); while (pbusy === 1'b1);
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic wait_irq;
    do @(negedge clk_sys_i); while (irq !== 1'b1);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk1("active", 1'b0, act);
    chk1("data_out", 1'b1, sdo);
    for (int o = 0; o < 2; o++)
    begin
      seed = lfsr(seed);
      cfg(`SSP_MODE_RX, 3'h0, o[0]);
      frame(seed[7:0]);
      ctl(1, 0, 0, 0, 0);
      wait_irq;
      chk8("rx_data", seed[7:0], rxd);
      chk1("full", 1'b1, full);
      q.push_back(seed[7:0]);
      ctl(0, 1, 0, 0, 0);
      ctl(0, 0, 0, 0, 1);
      do @(negedge clk_sys_i); while (act !== 1'b0);
      chk1("full", 1'b0, full);
    end
    @(posedge clk_sys_i);
    rdy <= 1'b1;
    foreach (q[i])
    begin
      do @(negedge clk_sys_i); while (sv !== 1'b1);
      chk8("stream", q[i], sd);
      @(posedge clk_sys_i);
    end
    @(negedge clk_sys_i);
    chk1("stream_valid", 1'b0, sv);
    $display("test internal receive done");
    seed = lfsr(seed);
    cfg(`SSP_MODE_TX, `SSP_CLKSEL_EXT, seed[8]);
    txd <= seed[7:0];
    ctl(0, 0, 0, 1, 0);
    @(negedge clk_sys_i);
    chk1("empty", 1'b0, emp);
    ctl(1, 0, 0, 0, 0);
    frame(8'h00);
    chk8("far_rx", seed[7:0], prx);
    frame(8'h00);
    @(negedge clk_sys_i);
    chk1("tx_error", 1'b1, txe);
    chk1("data_out", 1'b1, sdo);
    ctl(0, 0, 1, 0, 0);
    @(negedge clk_sys_i);
    chk1("tx_error", 1'b0, txe);
    chk1("start", 1'b0, st);
    $display("test external transmit done");
    seed = lfsr(seed);
    cfg(`SSP_MODE_RX, `SSP_CLKSEL_EXT, seed[9]);
    ctl(1, 0, 0, 0, 0);
    frame(seed[7:0]);
    frame(seed[15:8]);
    @(negedge clk_sys_i);
    chk1("rx_error", 1'b1, rxe);
    frame(seed[23:16]);
    ctl(0, 1, 0, 0, 0);
    @(negedge clk_sys_i);
    chk8("rx_data", seed[7:0], rxd);
    ctl(0, 0, 0, 0, 1);
    @(negedge clk_sys_i);
    chk8("rx_data", seed[15:8], rxd);
    ctl(0, 0, 0, 0, 1);
    @(negedge clk_sys_i);
    chk1("full", 1'b0, full);
    chk1("rx_error", 1'b0, rxe);
    ctl(0, 0, 1, 0, 0);
    $display("test receive overrun done");
    seed = lfsr(seed);
    cfg(`SSP_MODE_TXRX, 3'h1, seed[10]);
    txd <= seed[7:0];
    frame(seed[15:8]);
    ctl(0, 0, 0, 1, 0);
    ctl(1, 0, 0, 0, 0);
    wait_irq;
    chk8("rx_data", seed[15:8], rxd);
    chk1("empty", 1'b1, emp);
    repeat (4) @(posedge clk_sys_i);
    chk8("far_rx", seed[7:0], prx);
    ctl(0, 0, 0, 1, 0);
    @(negedge clk_sys_i);
    chk1("empty", 1'b0, emp);
    ctl(0, 0, 1, 0, 0);
    $display("test full duplex done");
    seed = lfsr(seed);
    cfg(`SSP_MODE_TXRX, `SSP_CLKSEL_EXT, seed[11]);
    txd <= seed[7:0];
    ctl(0, 0, 0, 1, 0);
    ctl(1, 0, 0, 0, 0);
    frame(seed[15:8]);
    chk8("far_rx", seed[7:0], prx);
    chk8("rx_data", seed[15:8], rxd);
    ctl(0, 0, 0, 0, 1);
    frame(seed[23:16]);
    @(negedge clk_sys_i);
    chk1("tx_error", 1'b1, txe);
    chk8("rx_data", seed[23:16], rxd);
    chk1("data_out", 1'b1, sdo);
    ctl(0, 0, 0, 0, 1);
    ctl(0, 0, 1, 0, 0);
    $display("test external duplex error done");
    print_verdict;
  end
endmodule
`default_nettype wire
